// File: src/spl_core.sv
`timescale 1ns/10ps
`default_nettype none
//==============================================================================
// serial unit: register file, pin control and shift engine
//==============================================================================
module spl_core
(
   // clock and reset
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   // apb slave
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [9:0]             paddr,
   input  wire logic [31:0]            pwdata,
   output logic      [31:0]            prdata,
   output logic                        pready,
   output logic                        pslverr,
   // pin levels
   input  wire logic                   sclk_in,
   input  wire logic                   mosi_in,
   input  wire logic                   miso_in,
   input  wire logic                   ss_n_in,
   // shared port drive used while the unit does not own a pin
   input  wire spl_pkg::spl_drive_type port_sclk,
   input  wire spl_pkg::spl_drive_type port_mosi,
   input  wire spl_pkg::spl_drive_type port_miso,
   input  wire spl_pkg::spl_drive_type port_ss,
   // pin drive
   output spl_pkg::spl_drive_type      sclk_drive,
   output spl_pkg::spl_drive_type      mosi_drive,
   output spl_pkg::spl_drive_type      miso_drive,
   output spl_pkg::spl_drive_type      ss_drive,
   output logic                        pullup_enable,
   output logic                        ss_port_level,
   // interrupt requests
   output logic                        tx_irq,
   output logic                        rx_irq
);
   import spl_pkg::*;

   //===========================================================================
   // declarations
   //===========================================================================
   spl_control_type ctl;
   logic            err_ie;
   logic            mode_fault_flag_en;
   logic [1:0]      rate;
   logic            rx_full_flag;
   logic            ovrf_flag;
   logic            mode_fault_flag;
   logic            tx_full;
   logic [7:0]      tx_data;
   logic [7:0]      rx_data;
   logic [7:0]      shift;
   logic            sample_bit;
   logic            out_bit;
   logic [4:0]      edge_cnt;
   spl_state_type   state;
   logic            sclk_lvl;
   logic            sclk_prev;
   logic            ss_prev;
   logic            done;
   logic [7:0]      done_byte;
   logic            ovrf_armed;
   logic            mode_fault_flag_armed;
   logic            wr_ctl;
   logic            wr_sta;
   logic            wr_dat;
   logic            rd_sta;
   logic            rd_dat;
   logic            access;
   logic            setup;
   logic            mapped;
   logic            en;
   logic            is_master;
   logic            is_slave;
   logic            ss_fall;
   logic            ss_rise;
   logic            tick;
   logic            eng_edge;
   logic            eng_lead;
   logic            slave_edge;
   logic            load;
   logic            slave_start0;
   logic            slave_start1;
   logic            in_pin;
   logic            fault_master;
   logic            fault_slave;
   logic [7:0]      status_val;
   logic [7:0]      read_val;

   //===========================================================================
   // apb decode
   //===========================================================================
   assign setup   = psel && !penable;
   assign access  = psel && penable;
   assign mapped  = (paddr == SPL_ADDR_CONTROL) || (paddr == SPL_ADDR_STATUS)
                    || (paddr == SPL_ADDR_DATA);
   assign pready  = 1'b1;                       // no wait states
   assign pslverr = access && !mapped;
   assign wr_ctl  = access && pwrite && (paddr == SPL_ADDR_CONTROL);
   assign wr_sta  = access && pwrite && (paddr == SPL_ADDR_STATUS);
   assign wr_dat  = access && pwrite && (paddr == SPL_ADDR_DATA);
   assign rd_sta  = access && !pwrite && (paddr == SPL_ADDR_STATUS);
   assign rd_dat  = access && !pwrite && (paddr == SPL_ADDR_DATA);

   // mode decode
   assign en        = ctl.module_enable;
   assign is_master = en && ctl.master_select;
   assign is_slave  = en && !ctl.master_select;

   assign status_val = {rx_full_flag, err_ie, ovrf_flag, mode_fault_flag,
                        !tx_full, mode_fault_flag_en, rate};

   // read mux, captured in the setup cycle
   always_comb
   begin
      read_val = 8'h00;
      if (paddr == SPL_ADDR_CONTROL)
         read_val = {ctl.rx_full_irq_enable, 1'b0, ctl.master_select, ctl.cpol,
                     ctl.cpha, ctl.wired_or_select, ctl.module_enable,
                     ctl.tx_empty_irq_enable};
      else if (paddr == SPL_ADDR_STATUS)
         read_val = status_val;
      else if (paddr == SPL_ADDR_DATA)
         read_val = rx_data;
   end

   // registered read data; the access edge sees the same value
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (setup && !pwrite)
         prdata <= {24'h00_0000, read_val};
   end

   //===========================================================================
   // pin events
   //===========================================================================
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sclk_prev <= 1'b0;
         ss_prev   <= 1'b1;
      end
      else
      begin
         sclk_prev <= sclk_in;
         ss_prev   <= ss_n_in;
      end
   end

   assign ss_fall = ss_prev && !ss_n_in;
   assign ss_rise = !ss_prev && ss_n_in;

   // deselected slave ignores clock edges
   assign slave_edge = is_slave && !ss_n_in && (sclk_in != sclk_prev);

   // one engine edge from either source; leading edge leaves idle level
   always_comb
   begin
      eng_edge = 1'b0;
      eng_lead = 1'b0;
      if (is_master)
      begin
         eng_edge = tick;
         eng_lead = (sclk_lvl == ctl.cpol);
      end
      else if (is_slave)
      begin
         eng_edge = slave_edge;
         eng_lead = (sclk_in != ctl.cpol);
      end
   end

   assign in_pin       = is_master ? miso_in : mosi_in;
   assign slave_start0 = is_slave && !ctl.cpha && ss_fall;
   assign slave_start1 = is_slave && ctl.cpha && eng_edge && eng_lead;
   // transmit byte moves only while the engine is idle
   assign load = en && tx_full && (state == SPL_IDLE) && !slave_start0;

   //===========================================================================
   // master clock divider
   //===========================================================================
   spl_rate_gen u_rate
   (
      .pclk    (pclk),
      .presetn (presetn),
      .run     (is_master && (state == SPL_RUN)),
      .divisor (spl_divisor(rate)),
      .tick    (tick)
   );

   //===========================================================================
   // shift engine
   //===========================================================================
   // disable returns state, shift, edge count and clock level to idle; out_bit, sample_bit and done_byte keep their values
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state      <= SPL_IDLE;
         shift      <= 8'h00;
         sample_bit <= 1'b0;
         out_bit    <= 1'b0;
         edge_cnt   <= 5'h00;
         sclk_lvl   <= 1'b0;
         done       <= 1'b0;
         done_byte  <= 8'h00;
      end
      else if (!en)
      begin
         state      <= SPL_IDLE;
         shift      <= 8'h00;
         edge_cnt   <= 5'h00;
         sclk_lvl   <= ctl.cpol;
         done       <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         case (state)
            SPL_IDLE:
            begin
               sclk_lvl <= ctl.cpol;
               edge_cnt <= 5'h00;
               if (load)
               begin
                  shift   <= tx_data;
                  out_bit <= tx_data[7];
                  if (is_master)
                     state <= SPL_RUN;
               end
               else if (slave_start0)
               begin
                  out_bit <= shift[7];
                  state   <= SPL_RUN;
               end
               else if (slave_start1)
               begin
                  out_bit  <= shift[7];                    // first edge counts
                  edge_cnt <= 5'h01;
                  state    <= SPL_RUN;
               end
            end
            SPL_RUN:
            begin
               if (eng_edge)
               begin
                  if (is_master)
                     sclk_lvl <= !sclk_lvl;
                  edge_cnt <= edge_cnt + 5'h01;
                  if (eng_lead)
                  begin
                     if (ctl.cpha)
                        out_bit <= shift[7];
                     else
                        sample_bit <= in_pin;
                  end
                  else if (ctl.cpha)
                     shift <= {shift[6:0], in_pin};
                  else
                  begin
                     shift   <= {shift[6:0], sample_bit};
                     out_bit <= shift[6];
                  end
                  // sixteen edges make eight clock cycles
                  if (edge_cnt == SPL_EDGES_PER_BYTE - 5'h01)
                  begin
                     state     <= SPL_IDLE;
                     done      <= 1'b1;
                     done_byte <= ctl.cpha ? {shift[6:0], in_pin}
                                           : {shift[6:0], sample_bit};
                  end
               end
            end
            default: state <= SPL_IDLE;
         endcase
      end
   end

   //===========================================================================
   // control register
   //===========================================================================
   // a master fault drops the enable on its own
   assign fault_master = is_master && mode_fault_flag_en && !ss_n_in;
   assign fault_slave  = is_slave && mode_fault_flag_en && ss_rise && (state == SPL_RUN);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctl <= spl_control_type'({SPL_CONTROL_RESET[7], SPL_CONTROL_RESET[5:0]}); // bit 6 unused
      else if (fault_master)
         ctl.module_enable <= 1'b0;
      else if (wr_ctl)
      begin
         ctl.rx_full_irq_enable  <= pwdata[SPL_CTL_RX_IE];
         ctl.master_select       <= pwdata[SPL_CTL_MASTER];
         ctl.cpol                <= pwdata[SPL_CTL_CPOL];
         ctl.cpha                <= pwdata[SPL_CTL_CPHA];
         ctl.wired_or_select     <= pwdata[SPL_CTL_WOM];
         ctl.module_enable       <= pwdata[SPL_CTL_ENABLE];
         ctl.tx_empty_irq_enable <= pwdata[SPL_CTL_TX_IE];
      end
   end

   // writable status bits, kept across a partial reset
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         err_ie  <= 1'b0;
         mode_fault_flag_en <= 1'b0;
         rate    <= 2'b00;
      end
      else if (wr_sta)
      begin
         err_ie  <= pwdata[SPL_STA_ERR_IE];
         mode_fault_flag_en <= pwdata[SPL_STA_MODE_FAULT_ENABLE];
         rate    <= {pwdata[SPL_STA_RATE_HI], pwdata[SPL_STA_RATE_LO]};
      end
   end

   //===========================================================================
   // transmit buffer
   //===========================================================================
   // empty flag is the inverse of full; disable forces empty
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tx_full <= 1'b0;
         tx_data <= 8'h00;
      end
      else
      begin
         if (wr_dat)
            tx_data <= pwdata[7:0];
         if (!en)
            tx_full <= 1'b0;
         else if (wr_dat)
            tx_full <= 1'b1;
         else if (load)
            tx_full <= 1'b0;
      end
   end

   //===========================================================================
   // receive side and error flags
   //===========================================================================
   // clearing an error flag takes a status read with the flag set, then a second access
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rx_data         <= 8'h00;
         rx_full_flag    <= 1'b0;
         ovrf_flag       <= 1'b0;
         mode_fault_flag <= 1'b0;
         ovrf_armed      <= 1'b0;
         mode_fault_flag_armed      <= 1'b0;
      end
      else
      begin
         if (rd_sta)
         begin
            ovrf_armed <= prdata[SPL_STA_OVRF];
            mode_fault_flag_armed <= prdata[SPL_STA_MODE_FAULT_FLAG];
         end
         // new byte wins over a clearing read in the same cycle
         if (done && !rx_full_flag)
         begin
            rx_data      <= done_byte;
            rx_full_flag <= 1'b1;
         end
         else if (done && rx_full_flag && !rd_dat)
            ovrf_flag <= 1'b1;                     // last shifted byte is lost
         else if (done && rd_dat)
         begin
            rx_data      <= done_byte;
            rx_full_flag <= 1'b1;
         end
         else if (rd_dat)
            rx_full_flag <= 1'b0;
         if (rd_dat && ovrf_armed && !(done && rx_full_flag && !rd_dat))
         begin
            ovrf_flag  <= 1'b0;
            ovrf_armed <= 1'b0;
         end
         if (fault_master || fault_slave)
            mode_fault_flag <= 1'b1;
         else if (wr_ctl && mode_fault_flag_armed)
         begin
            mode_fault_flag <= 1'b0;
            mode_fault_flag_armed      <= 1'b0;
         end
      end
   end

   //===========================================================================
   // pin drive
   //===========================================================================
   // open drain only pulls low; push-pull drives both levels
   function automatic spl_drive_type spl_pin(input logic drive, input logic val,
                                             input logic wom);
      spl_pin.out = wom ? 1'b0 : val;
      spl_pin.oe  = wom ? (drive && !val) : drive;
   endfunction : spl_pin

   always_comb
   begin
      sclk_drive = port_sclk;
      mosi_drive = port_mosi;
      miso_drive = port_miso;
      ss_drive   = port_ss;
      if (is_master)
      begin
         sclk_drive = spl_pin(1'b1, sclk_lvl, ctl.wired_or_select);
         mosi_drive = spl_pin(1'b1, out_bit, ctl.wired_or_select);
         miso_drive = '{out: 1'b0, oe: 1'b0};
         if (mode_fault_flag_en)
            ss_drive = '{out: 1'b0, oe: 1'b0};
      end
      else if (is_slave)
      begin
         sclk_drive = '{out: 1'b0, oe: 1'b0};
         mosi_drive = '{out: 1'b0, oe: 1'b0};
         miso_drive = spl_pin(!ss_n_in, out_bit, ctl.wired_or_select);
         ss_drive   = '{out: 1'b0, oe: 1'b0};
      end
   end

   assign pullup_enable = !ctl.wired_or_select;
   assign ss_port_level = ss_n_in;

   //===========================================================================
   // interrupt requests
   //===========================================================================
   assign tx_irq = ctl.tx_empty_irq_enable && !tx_full;
   assign rx_irq = (ctl.rx_full_irq_enable && en && rx_full_flag)
                   || (ctl.rx_full_irq_enable && err_ie
                       && (ovrf_flag || mode_fault_flag));

endmodule : spl_core
`default_nettype wire

// File: src/spl_pkg.sv
//==============================================================================
// constants and types of the serial pin and control block
//==============================================================================
package spl_pkg;

   //===========================================================================
   // register map: printed offsets are indices, byte address is four times
   //===========================================================================
   localparam logic [7:0] SPL_IDX_CONTROL  = 8'h10;
   localparam logic [7:0] SPL_IDX_STATUS   = 8'h11;
   localparam logic [7:0] SPL_IDX_DATA     = 8'h12;
   localparam logic [9:0] SPL_ADDR_CONTROL = {SPL_IDX_CONTROL, 2'b00};
   localparam logic [9:0] SPL_ADDR_STATUS  = {SPL_IDX_STATUS, 2'b00};
   localparam logic [9:0] SPL_ADDR_DATA    = {SPL_IDX_DATA, 2'b00};

   //===========================================================================
   // field positions
   //===========================================================================
   localparam int SPL_CTL_RX_IE   = 7;
   localparam int SPL_CTL_MASTER  = 5;
   localparam int SPL_CTL_CPOL    = 4;
   localparam int SPL_CTL_CPHA    = 3;
   localparam int SPL_CTL_WOM     = 2;
   localparam int SPL_CTL_ENABLE  = 1;
   localparam int SPL_CTL_TX_IE   = 0;
   localparam int SPL_STA_RX_FULL = 7;
   localparam int SPL_STA_ERR_IE  = 6;
   localparam int SPL_STA_OVRF    = 5;
   localparam int SPL_STA_MODE_FAULT_FLAG    = 4;
   localparam int SPL_STA_TX_EMPT = 3;
   localparam int SPL_STA_MODE_FAULT_ENABLE  = 2;
   localparam int SPL_STA_RATE_HI = 1;
   localparam int SPL_STA_RATE_LO = 0;

   //===========================================================================
   // reset values and timing
   //===========================================================================
   localparam logic [7:0] SPL_CONTROL_RESET = 8'h28;
   localparam logic [4:0] SPL_EDGES_PER_BYTE = 5'h10;
   localparam logic [7:0] SPL_DIV_0 = 8'h02;
   localparam logic [7:0] SPL_DIV_1 = 8'h08;
   localparam logic [7:0] SPL_DIV_2 = 8'h20;
   localparam logic [7:0] SPL_DIV_3 = 8'h80;

   //===========================================================================
   // types
   //===========================================================================
   typedef enum logic {SPL_IDLE, SPL_RUN} spl_state_type;

   // one pin as seen from a driver
   typedef struct packed {
      logic out;
      logic oe;
   } spl_drive_type;

   // control register fields
   typedef struct packed {
      logic rx_full_irq_enable;
      logic master_select;
      logic cpol;
      logic cpha;
      logic wired_or_select;
      logic module_enable;
      logic tx_empty_irq_enable;
   } spl_control_type;

   // baud divisor from the two rate bits
   function automatic logic [7:0] spl_divisor(input logic [1:0] rate);
      case (rate)
         2'b00:   spl_divisor = SPL_DIV_0;
         2'b01:   spl_divisor = SPL_DIV_1;
         2'b10:   spl_divisor = SPL_DIV_2;
         default: spl_divisor = SPL_DIV_3;
      endcase
   endfunction : spl_divisor

endpackage : spl_pkg

// File: src/spl_rate_gen.sv
`timescale 1ns/10ps
`default_nettype none
//==============================================================================
// half-period tick generator for the master clock
//==============================================================================
module spl_rate_gen
(
   // clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // control
   input  wire logic       run,
   input  wire logic [7:0] divisor,
   // tick
   output logic            tick
);
   import spl_pkg::*;

   logic [7:0] count;

   // restart from zero whenever idle so the first half period is whole
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         count <= 8'h00;
      else if (!run || tick)
         count <= 8'h00;
      else
         count <= count + 8'h01;
   end

   assign tick = run && (count == divisor - 8'h01);

endmodule : spl_rate_gen
`default_nettype wire

// File: verif/spl_core_props.sv
`timescale 1ns/10ps
`default_nettype none
//==============================================================================
// pin ownership checks
//==============================================================================
module spl_core_props
   import spl_pkg::*;
(
   // bus
   input wire logic                   pclk,
   input wire logic                   presetn,
   input wire logic                   psel,
   input wire logic                   penable,
   input wire logic                   pwrite,
   input wire logic [9:0]             paddr,
   input wire logic [31:0]            pwdata,
   // pins
   input wire logic                   ss_n_in,
   input wire spl_pkg::spl_drive_type port_sclk,
   input wire spl_pkg::spl_drive_type sclk_drive,
   input wire spl_pkg::spl_drive_type mosi_drive,
   input wire spl_pkg::spl_drive_type miso_drive,
   input wire spl_pkg::spl_drive_type ss_drive,
   input wire logic                   pullup_enable,
   input wire logic                   ss_port_level
);
   logic [7:0] ctl;
   logic       en;
   logic       slv;
   logic       mfe;

   // shadow of control, so ownership is judged from the ports alone
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         ctl <= SPL_CONTROL_RESET;
      else if (en && ctl[SPL_CTL_MASTER] && mfe && !ss_n_in)
         ctl[SPL_CTL_ENABLE] <= 1'b0;   // master fault drops the enable
      else if (psel && penable && pwrite && paddr == SPL_ADDR_CONTROL)
         ctl <= pwdata[7:0];
   // shadow of the fault enable bit
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         mfe <= 1'b0;
      else if (psel && penable && pwrite && paddr == SPL_ADDR_STATUS)
         mfe <= pwdata[SPL_STA_MODE_FAULT_ENABLE];
   assign en  = ctl[SPL_CTL_ENABLE];
   assign slv = en && !ctl[SPL_CTL_MASTER];

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // select level held long enough to clear the synchroniser
   sequence s_sel_low; !ss_n_in[*4]; endsequence
   sequence s_desel; ss_n_in[*4]; endsequence

   a_wom_pullup: assert property (pullup_enable == !ctl[SPL_CTL_WOM])
      else $error("pullup level wrong");
   a_slave_noclk: assert property (slv |-> !sclk_drive.oe)
      else $error("slave drives clock");
   a_master_own: assert property (en && !slv && !ctl[SPL_CTL_WOM]
      |-> sclk_drive.oe && mosi_drive.oe && !miso_drive.oe)
      else $error("master pin direction wrong");
   a_slave_miso: assert property (s_sel_low ##0 (slv && !ctl[SPL_CTL_WOM]) |-> miso_drive.oe)
      else $error("selected slave silent");
   a_desel_float: assert property (s_desel ##0 slv |-> !miso_drive.oe)
      else $error("deselected slave drives");
   a_slave_ssin: assert property (slv |-> !ss_drive.oe)
      else $error("slave select driven");
   a_port_owns: assert property (!en |-> sclk_drive == port_sclk)
      else $error("port lost clock pin");
   a_ss_level: assert property (ss_port_level == ss_n_in)
      else $error("select level hidden");
endmodule : spl_core_props

bind spl_core spl_core_props u_props (.*);
`default_nettype wire

// File: verif/spl_far_end.sv
`timescale 1ns/10ps
`default_nettype none
//==============================================================================
// far-end slave, polarity 0 phase 1
//==============================================================================
module spl_far_end
(
   // link
   input  wire logic       sclk,
   input  wire logic       mosi,
   input  wire logic       ss_n,
   // bench side
   input  wire logic [7:0] tx,
   output logic            miso,
   output logic [7:0]      rx,
   output int              edges
);
   int k = 0;

   initial miso = 1'b0;
   initial edges = 0;
   // msb first out on leading edge, sampled on trailing
   always @(posedge sclk)
      if (!ss_n)
         miso = tx[7 - k];
   always @(negedge sclk)
      if (!ss_n)
      begin
         rx = {rx[6:0], mosi};
         k = (k + 1) % 8;
         edges++;
         if (k == 0)
            miso = ~miso; // inverted after the eighth bit: no stale bit
      end
   always @(posedge ss_n) miso = ~miso;
endmodule : spl_far_end
`default_nettype wire

// File: verif/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; \
   $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
//==============================================================================
// bench: master transfers, then slave and disable checks
//==============================================================================
module testbench;
   import spl_pkg::*;
   typedef struct {logic [7:0] dut_tx; logic [7:0] far_tx;} spl_row_type;
   logic          pclk, presetn, psel, penable, pwrite, ss_n, err;
   logic          pready, pslverr, pullup_enable, ss_port_level, tx_irq, rx_irq, miso_far;
   logic [9:0]    paddr;
   logic [31:0]   pwdata, prdata, r;
   logic [7:0]    far_tx, far_rx;
   spl_drive_type port_d, sclk_drive, mosi_drive, miso_drive, ss_drive;
   int            err_total, tests_run, edges, i, n;
   spl_row_type   rows [3] = '{'{8'h00, 8'hFF}, '{8'hA5, 8'h3C}, '{8'hFF, 8'h01}};
   // idle far-end master holds its clock and data low
   wire logic     sclk_in = sclk_drive.oe ? sclk_drive.out : 1'b0;
   wire logic     mosi_in = mosi_drive.oe ? mosi_drive.out : 1'b0;
   wire logic     miso_in = miso_drive.oe ? miso_drive.out : miso_far;
   wire logic     ss_n_in = ss_n;

   spl_core dut_u (.port_sclk(port_d), .port_mosi(port_d), .port_miso(port_d),
      .port_ss(port_d), .*);
   spl_far_end far_u (.sclk(sclk_in), .mosi(mosi_in), .ss_n(ss_n), .tx(far_tx),
      .miso(miso_far), .rx(far_rx), .edges(edges));

   initial
   begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   // one apb transfer, one idle cycle after
   task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= {24'h00_0000, d};
      @(posedge pclk) penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata; err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic final_report;
      $display("checks %0d errors %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : final_report

   // whole run needs under 2000 cycles
   initial
   begin
      #200us;
      err_total++;
      final_report;
   end

   initial
   begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      presetn = 1'b0; ss_n = 1'b1; port_d = 2'b01; far_tx = 8'h00;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(0, SPL_ADDR_CONTROL, 0); `CHK(r, 32'h0000_0028)
      apb(0, SPL_ADDR_STATUS, 0); `CHK(r, 32'h0000_0008)
      `CHK(tx_irq | rx_irq, 1'b0)
      apb(0, 10'h3FC, 0); `CHK(err, 1'b1)
      apb(1, SPL_ADDR_CONTROL, 8'hAA);
      ss_n <= 1'b0; // held low across bytes
      for (i = 0; i < 3; i++)
      begin
         far_tx = rows[i].far_tx;
         apb(1, SPL_ADDR_DATA, rows[i].dut_tx);
         n = 0; r = '0;
         while (r[SPL_STA_RX_FULL] !== 1'b1 && n++ < 100) apb(0, SPL_ADDR_STATUS, 0);
         `CHK(rx_irq, 1'b1)
         apb(0, SPL_ADDR_DATA, 0);
         `CHK(r[7:0], rows[i].far_tx)
         `CHK(far_rx, rows[i].dut_tx)
         `CHK(edges, 8 * (i + 1))
      end
      `CHK(ss_drive, port_d)
      apb(0, SPL_ADDR_STATUS, 0); `CHK(r[SPL_STA_MODE_FAULT_FLAG], 1'b0)
      apb(1, SPL_ADDR_CONTROL, 8'h2E); `CHK(pullup_enable, 1'b0)
      apb(1, SPL_ADDR_CONTROL, 8'h02);
      // phase 0 slave: select raised between bytes
      ss_n <= 1'b1; repeat (6) @(posedge pclk); `CHK(miso_drive.oe, 1'b0)
      apb(1, SPL_ADDR_DATA, 8'h80); // loaded before the select falls
      ss_n <= 1'b0; repeat (6) @(posedge pclk); `CHK(miso_drive.oe, 1'b1)
      `CHK(miso_drive.out, 1'b1)
      `CHK(ss_drive.oe, 1'b0)
      apb(1, SPL_ADDR_CONTROL, 8'h08);
      apb(0, SPL_ADDR_STATUS, 0); `CHK(r[SPL_STA_TX_EMPT], 1'b1)
      `CHK(sclk_drive, port_d)
      // master with fault detection sees its select low
      apb(1, SPL_ADDR_CONTROL, 8'h2A);
      apb(1, SPL_ADDR_STATUS, 8'h04);
      apb(0, SPL_ADDR_CONTROL, 0); `CHK(r[SPL_CTL_ENABLE], 1'b0)
      apb(0, SPL_ADDR_STATUS, 0); `CHK(r[SPL_STA_MODE_FAULT_FLAG], 1'b1)
      apb(1, SPL_ADDR_CONTROL, 8'h09); `CHK(tx_irq, 1'b1)
      final_report;
   end
endmodule : testbench
`default_nettype wire
